// File: verilog/sfs_regs.svh
/*
 * Register map, field positions, reset values and counts of the
 * FIFO status and infrared mode block.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// Byte offsets of the registers
`define SFS_OFS_FILL      8'h00
`define SFS_OFS_ERRMAP    8'h04
`define SFS_OFS_IRMODE    8'h08
`define SFS_OFS_FIFOCTL   8'h0C
`define SFS_OFS_SERMODE   8'h10
`define SFS_OFS_BITRATE   8'h14

// Fill count layout
`define SFS_TX_CNT_LSB    8
`define SFS_CNT_W         5
`define SFS_FIFO_DEPTH    5'h10

// Infrared mode register fields
`define SFS_IR_SELECT     7
`define SFS_IR_PSEL       6
`define SFS_IR_RXPOL      5
`define SFS_IRMODE_RST    8'h00

// FIFO control register fields
`define SFS_TX_CLEAR      2
`define SFS_RX_CLEAR      1

// Serial mode register fields
`define SFS_SER_SYNC      7
`define SFS_ICK_MSB       6
`define SFS_ICK_LSB       3

// Infrared pulse lasts this many of the 16 ticks per bit
`define SFS_IR_PULSE_TICKS 2'h3
`define SFS_TICKS_PER_BIT  4'hF

`endif

// File: verilog/sfs_pkg.sv
/*
 * Types shared by the FIFO status and infrared mode block.
 * Assumes the constants of sfs_regs.svh.
 */
package sfs_pkg;
	// Infrared transmit pulse shaper states
	typedef enum logic [0:0] {
		SFS_IRTX_IDLE,
		SFS_IRTX_PULSE
	} sfs_irtx_state_t;

	typedef logic [4:0] sfs_count_t;
endpackage

// File: verilog/sfs_core.sv
/*
 * Status and configuration part of a FIFO serial unit: fill counts of
 * the 16-stage transmit and receive FIFOs, receive error map per stage,
 * infrared mode control, infrared pulse clock and pulse shaping.
 * Assumes FIFO storage and the serial engine sit outside on the same
 * clock and report one-cycle push and pop strobes; standby inputs are
 * asynchronous levels.
 */
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "sfs_regs.svh"

// Behaviour
// - Fill register: tx count high, rx low
// - Fill counts clear on reset and standby
// - FIFO clear bits empty FIFOs, zero counts
// - Tx count sits in bits 12..8
// - Tx count 0 empty, 16 full
// - Rx count bits 4..0, 0 to 16
// - Reserved bits read zero, write zero
// - Error map bit n flags stage n
// - Rx FIFO clear leaves error map
// - Error flag clears on byte read, reset
// - Infrared register clears on reset, standby
// - Bit 7 selects infrared operation
// - Pulse is 3/16 of bit length, or 3 pulse clocks with bit 6 set
// - Pulse clock is clock over 2N+2
// - Rx polarity bit 0 inverts data in infrared mode
// - Tx clear empties transmit FIFO while set
// - Rx clear empties receive FIFO while set
module sfs_core
	import sfs_pkg::*;
(
	input  wire logic             CORE_CLK_IN,      // 200 MHz clock
	input  wire logic             RST_IN,           // Sync reset, high
	input  wire logic             MOD_STANDBY_IN,   // Module standby, async
	input  wire logic             STANDBY_IN,       // Standby mode, async
	input  wire logic             WB_CYC_IN,        // Bus cycle
	input  wire logic             WB_STB_IN,        // Bus strobe
	input  wire logic             WB_WE_IN,         // Write enable
	input  wire logic [7:0]       WB_ADR_IN,        // Byte address
	input  wire logic [3:0]       WB_SEL_IN,        // Byte lanes
	input  wire logic [31:0]      WB_DAT_IN,        // Write data
	output logic      [31:0]      WB_DAT_OUT,       // Read data
	output logic                  WB_ACK_OUT,       // Acknowledge
	input  wire logic             TX_PUSH_IN,       // Byte queued for tx
	input  wire logic             TX_POP_IN,        // Engine took tx byte
	input  wire logic             RX_PUSH_IN,       // Engine stored rx byte
	input  wire logic             RX_ERR_IN,        // Parity/framing error
	input  wire logic             RX_POP_IN,        // Software read rx byte
	input  wire logic             TX_BIT_START_IN,  // Start of a tx bit
	input  wire logic             TX_BIT_IN,        // Serial tx bit value
	input  wire logic             IR_RX_IN,         // Pin from transceiver
	output logic                  IR_TX_OUT,        // Pin to transceiver
	output logic                  RX_DATA_OUT,      // Rx data to engine
	output logic                  TX_FIFO_CLEAR_OUT,// Empty tx FIFO
	output logic                  RX_FIFO_CLEAR_OUT,// Empty rx FIFO
	output logic                  IR_MODE_OUT,      // Infrared selected
	output logic                  IR_CLK_EN_OUT,    // Pulse clock enable
	output logic                  TX_FULL_OUT,      // Tx FIFO full
	output logic                  RX_EMPTY_OUT      // Rx FIFO empty
);
	import sfs_pkg::*;

	// Two-stage synchronisers for asynchronous levels
	logic [1:0] sby_mod_s_r;
	logic [1:0] sby_s_r;
	logic [1:0] irrx_s_r;

	always_ff @(posedge CORE_CLK_IN) begin
		sby_mod_s_r <= {sby_mod_s_r[0], MOD_STANDBY_IN};
		sby_s_r     <= {sby_s_r[0], STANDBY_IN};
		irrx_s_r    <= {irrx_s_r[0], IR_RX_IN};
	end

	// Standby clears the software registers, counts, error map, dividers and shaper state
	logic sby;
	assign sby = sby_mod_s_r[1] | sby_s_r[1];

	// Bus decode
	logic bus_req;
	logic bus_wr;
	logic lane0;
	assign bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	assign bus_wr  = bus_req & WB_WE_IN;
	assign lane0   = WB_SEL_IN[0];

	// Software registers
	logic [7:3]   irmode_r, irmode_nxt;
	logic [2:1]   fifoctl_r, fifoctl_nxt;
	logic [7:3]   sermode_r, sermode_nxt;
	logic [7:0]   bitrate_r, bitrate_nxt;

	always_comb begin
		irmode_nxt  = irmode_r;
		fifoctl_nxt = fifoctl_r;
		sermode_nxt = sermode_r;
		bitrate_nxt = bitrate_r;
		if (sby) begin
			irmode_nxt  = '0;
			fifoctl_nxt = '0;
			sermode_nxt = '0;
			bitrate_nxt = '0;
		end else if (bus_wr && lane0) begin
			unique case (WB_ADR_IN)
				`SFS_OFS_IRMODE: irmode_nxt = {WB_DAT_IN[7:5], 2'h0};
				`SFS_OFS_FIFOCTL: fifoctl_nxt = WB_DAT_IN[2:1];
				`SFS_OFS_SERMODE: sermode_nxt = WB_DAT_IN[7:3];
				`SFS_OFS_BITRATE: bitrate_nxt = WB_DAT_IN[7:0];
				default: ;
			endcase
		end
	end

	// Bits 4..3 of the infrared register are reserved and never stored
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			irmode_r  <= '0;
			fifoctl_r <= '0;
			sermode_r <= '0;
			bitrate_r <= '0;
		end else begin
			irmode_r  <= irmode_nxt;
			fifoctl_r <= fifoctl_nxt;
			sermode_r <= sermode_nxt;
			bitrate_r <= bitrate_nxt;
		end
	end

	logic tx_clr;
	logic rx_clr;
	assign tx_clr = fifoctl_r[`SFS_TX_CLEAR] | sby;
	assign rx_clr = fifoctl_r[`SFS_RX_CLEAR] | sby;

	// Fill counts and receive pointers
	sfs_count_t tx_cnt_r, tx_cnt_nxt;
	sfs_count_t rx_cnt_r, rx_cnt_nxt;
	logic [3:0] rx_wp_r, rx_wp_nxt;
	logic [3:0] rx_rp_r, rx_rp_nxt;
	logic       tx_do_push, tx_do_pop;
	logic       rx_do_push, rx_do_pop;

	// Full FIFO takes a push only beside a pop; empty pops are dropped
	always_comb begin
		tx_do_push = TX_PUSH_IN & (TX_POP_IN | tx_cnt_r != `SFS_FIFO_DEPTH);
		tx_do_pop  = TX_POP_IN & (tx_cnt_r != 5'h00);
		rx_do_push = RX_PUSH_IN & (RX_POP_IN | rx_cnt_r != `SFS_FIFO_DEPTH);
		rx_do_pop  = RX_POP_IN & (rx_cnt_r != 5'h00);
		tx_cnt_nxt = tx_cnt_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_wp_nxt  = rx_wp_r;
		rx_rp_nxt  = rx_rp_r;
		if (tx_clr) begin
			tx_cnt_nxt = 5'h00;
		end else if (tx_do_push && !tx_do_pop) begin
			tx_cnt_nxt = tx_cnt_r + 5'h01;
		end else if (tx_do_pop && !tx_do_push) begin
			tx_cnt_nxt = tx_cnt_r - 5'h01;
		end
		if (rx_clr) begin
			rx_cnt_nxt = 5'h00;
			rx_wp_nxt  = 4'h0;
			rx_rp_nxt  = 4'h0;
		end else begin
			if (rx_do_push && !rx_do_pop) begin
				rx_cnt_nxt = rx_cnt_r + 5'h01;
			end else if (rx_do_pop && !rx_do_push) begin
				rx_cnt_nxt = rx_cnt_r - 5'h01;
			end
			if (rx_do_push) begin
				rx_wp_nxt = rx_wp_r + 4'h1;
			end
			if (rx_do_pop) begin
				rx_rp_nxt = rx_rp_r + 4'h1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			tx_cnt_r <= 5'h00;
			rx_cnt_r <= 5'h00;
			rx_wp_r  <= 4'h0;
			rx_rp_r  <= 4'h0;
		end else begin
			tx_cnt_r <= tx_cnt_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_wp_r  <= rx_wp_nxt;
			rx_rp_r  <= rx_rp_nxt;
		end
	end

	// Error map per stage; the FIFO clear bit does not touch it
	logic [15:0] errmap_r, errmap_nxt;

	generate
		for (genvar n = 0; n < 16; n++) begin : g_err
			always_comb begin
				errmap_nxt[n] = errmap_r[n];
				if (sby) begin
					errmap_nxt[n] = 1'b0;
				end else if (rx_do_push && !rx_clr &&
				             rx_wp_r == 4'(n)) begin
					errmap_nxt[n] = RX_ERR_IN;
				end else if (rx_do_pop && !rx_clr &&
				             rx_rp_r == 4'(n)) begin
					errmap_nxt[n] = 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			errmap_r <= 16'h0000;
		end else begin
			errmap_r <= errmap_nxt;
		end
	end

	// Infrared pulse clock: period 2N+2 core cycles
	logic [4:0] irdiv_r, irdiv_nxt;
	logic       infrared_pulse_clock_en;
	logic [4:0] irdiv_top;
	assign irdiv_top = {sermode_r[`SFS_ICK_MSB:`SFS_ICK_LSB], 1'b1};
	assign infrared_pulse_clock_en  = (irdiv_r == irdiv_top);

	// Bit rate tick: one every bit_rate+1 cycles, 16 per bit
	logic [7:0] brdiv_r, brdiv_nxt;
	logic       brtick;
	assign brtick = (brdiv_r == bitrate_r);

	always_comb begin
		irdiv_nxt = infrared_pulse_clock_en ? 5'h00 : irdiv_r + 5'h01;
		brdiv_nxt = brtick ? 8'h00 : brdiv_r + 8'h01;
		if (sby) begin
			irdiv_nxt = 5'h00;
			brdiv_nxt = 8'h00;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			irdiv_r <= 5'h00;
			brdiv_r <= 8'h00;
		end else begin
			irdiv_r <= irdiv_nxt;
			brdiv_r <= brdiv_nxt;
		end
	end

	// Pulse shaper: a zero bit sends a 3-tick pulse of the chosen tick
	sfs_irtx_state_t irtx_st_r, irtx_st_nxt;
	logic [1:0]      irtx_cnt_r, irtx_cnt_nxt;
	logic            ir_tick;
	logic            ir_sel;
	assign ir_sel  = irmode_r[`SFS_IR_SELECT];
	assign ir_tick = irmode_r[`SFS_IR_PSEL] ? infrared_pulse_clock_en : brtick;

	always_comb begin
		irtx_st_nxt  = irtx_st_r;
		irtx_cnt_nxt = irtx_cnt_r;
		unique case (irtx_st_r)
			SFS_IRTX_IDLE: begin
				if (ir_sel && TX_BIT_START_IN && !TX_BIT_IN) begin
					irtx_st_nxt  = SFS_IRTX_PULSE;
					irtx_cnt_nxt = 2'h0;
				end
			end
			SFS_IRTX_PULSE: begin
				if (ir_tick) begin
					irtx_cnt_nxt = irtx_cnt_r + 2'h1;
					if (irtx_cnt_r == `SFS_IR_PULSE_TICKS - 2'h1) begin
						irtx_st_nxt = SFS_IRTX_IDLE;
					end
				end
			end
		endcase
		if (sby || !ir_sel) begin
			irtx_st_nxt = SFS_IRTX_IDLE;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			irtx_st_r  <= SFS_IRTX_IDLE;
			irtx_cnt_r <= 2'h0;
		end else begin
			irtx_st_r  <= irtx_st_nxt;
			irtx_cnt_r <= irtx_cnt_nxt;
		end
	end

	// Read mux; reserved and unmapped bits read as zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (WB_ADR_IN)
			`SFS_OFS_FILL: begin
				rd_data[`SFS_TX_CNT_LSB +: `SFS_CNT_W] = tx_cnt_r;
				rd_data[`SFS_CNT_W-1:0] = rx_cnt_r;
			end
			`SFS_OFS_ERRMAP:  rd_data[15:0] = errmap_r;
			`SFS_OFS_IRMODE:  rd_data[7:3]  = irmode_r;
			`SFS_OFS_FIFOCTL: rd_data[2:1]  = fifoctl_r;
			`SFS_OFS_SERMODE: rd_data[7:3]  = sermode_r;
			`SFS_OFS_BITRATE: rd_data[7:0]  = bitrate_r;
			default: ;
		endcase
	end

	// Output registers; every top output comes from a flip-flop
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			WB_ACK_OUT        <= 1'b0;
			WB_DAT_OUT        <= 32'h0000_0000;
			IR_TX_OUT         <= 1'b1;
			RX_DATA_OUT       <= 1'b1;
			TX_FIFO_CLEAR_OUT <= 1'b1;
			RX_FIFO_CLEAR_OUT <= 1'b1;
			IR_MODE_OUT       <= 1'b0;
			IR_CLK_EN_OUT     <= 1'b0;
			TX_FULL_OUT       <= 1'b0;
			RX_EMPTY_OUT      <= 1'b1;
		end else begin
			// One-cycle ack keeps every access a fixed two edges
			WB_ACK_OUT        <= bus_req;
			WB_DAT_OUT        <= bus_req ? rd_data : 32'h0000_0000;
			// Infrared line idles low; plain mode passes the bit
			IR_TX_OUT         <= ir_sel ? (irtx_st_r == SFS_IRTX_PULSE)
			                            : TX_BIT_IN;
			RX_DATA_OUT       <= (ir_sel && !irmode_r[`SFS_IR_RXPOL])
			                     ? ~irrx_s_r[1] : irrx_s_r[1];
			TX_FIFO_CLEAR_OUT <= tx_clr;
			RX_FIFO_CLEAR_OUT <= rx_clr;
			IR_MODE_OUT       <= ir_sel;
			IR_CLK_EN_OUT     <= infrared_pulse_clock_en;
			TX_FULL_OUT       <= (tx_cnt_nxt == `SFS_FIFO_DEPTH);
			RX_EMPTY_OUT      <= (rx_cnt_nxt == 5'h00);
		end
	end

endmodule

// File: sim/sfs_core_assertions.sv
/* Port checker for the FIFO status and infrared mode block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "sfs_regs.svh"
module sfs_chk (
	input wire logic        CORE_CLK_IN,     // Clock
	input wire logic        RST_IN,          // Reset
	input wire logic        WB_CYC_IN,       // Cycle
	input wire logic        WB_STB_IN,       // Strobe
	input wire logic        WB_WE_IN,        // Write
	input wire logic [7:0]  WB_ADR_IN,       // Address
	input wire logic [3:0]  WB_SEL_IN,       // Lanes
	input wire logic [31:0] WB_DAT_IN,       // Write data
	input wire logic [31:0] WB_DAT_OUT,      // Read data
	input wire logic        WB_ACK_OUT,      // Ack
	input wire logic        TX_PUSH_IN,      // Tx push
	input wire logic        TX_POP_IN,       // Tx pop
	input wire logic        RX_PUSH_IN,      // Rx push
	input wire logic        RX_POP_IN,       // Rx pop
	input wire logic        TX_BIT_START_IN, // Bit start
	input wire logic        TX_BIT_IN,       // Bit value
	input wire logic        IR_TX_OUT,       // Ir pin
	input wire logic        RX_FIFO_CLEAR_OUT, // Rx clear
	input wire logic        IR_MODE_OUT,     // Ir mode
	input wire logic        IR_CLK_EN_OUT,   // Pulse clock
	input wire logic        TX_FULL_OUT,     // Tx full
	input wire logic        RX_EMPTY_OUT     // Rx empty
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	// Write accepted at this edge, lane 0 enabled
	wire take = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	wire wr0 = take & WB_WE_IN & WB_SEL_IN[0];

	bus_ack_a: assert property (take |=> WB_ACK_OUT)
		else $error("no ack");
	ack_once_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack too long");
	fill_rsv_a: assert property (WB_ACK_OUT &&
		$past(WB_ADR_IN) == `SFS_OFS_FILL |-> WB_DAT_OUT[31:13] == 19'h0
		&& WB_DAT_OUT[7:5] == 3'h0) else $error("fill reserved set");
	ir_rsv_a: assert property (WB_ACK_OUT &&
		$past(WB_ADR_IN) == `SFS_OFS_IRMODE |-> WB_DAT_OUT[31:8] == 24'h0
		&& WB_DAT_OUT[4:0] == 5'h0) else $error("ir reserved set");
	// Reset must reach the flags even though checks pause in reset
	rst_clr_a: assert property (disable iff (1'b0) RST_IN |=>
		RX_EMPTY_OUT && !TX_FULL_OUT && !IR_MODE_OUT)
		else $error("reset state wrong");
	rx_clear_a: assert property (wr0 && WB_ADR_IN == `SFS_OFS_FIFOCTL &&
		WB_DAT_IN[1] |-> ##[1:3] RX_FIFO_CLEAR_OUT) else $error("no clear");
	ir_sel_a: assert property (wr0 && WB_ADR_IN == `SFS_OFS_IRMODE &&
		WB_DAT_IN[7] |-> ##[1:3] IR_MODE_OUT) else $error("no ir mode");
	full_hold_a: assert property (TX_FULL_OUT && !$past(TX_POP_IN) &&
		TX_PUSH_IN && !TX_POP_IN |=> TX_FULL_OUT) else $error("full lost");
	rx_push_a: assert property (RX_EMPTY_OUT && RX_PUSH_IN &&
		!RX_POP_IN && !RX_FIFO_CLEAR_OUT |-> ##1 !RX_EMPTY_OUT)
		else $error("still empty");
	infrared_pulse_clock_a: assert property (IR_CLK_EN_OUT |=> !IR_CLK_EN_OUT)
		else $error("pulse clock stuck");
	ir_pulse_a: assert property (IR_MODE_OUT && TX_BIT_START_IN &&
		!TX_BIT_IN |-> ##2 IR_TX_OUT) else $error("no ir pulse");
	// Main scenarios reached
	cover property (wr0);
	cover property (TX_FULL_OUT && TX_PUSH_IN);
	cover property (IR_MODE_OUT && IR_TX_OUT);
endmodule
bind sfs_core sfs_chk u_chk (.*);

// File: sim/sfs_ir_peer.sv
/* Infrared transceiver model: drives the receive line, times pulses.
   Assumes the block's clock; the line follows the bench's level. */
`timescale 1ns/1ps
module sfs_ir_peer (
	input  wire logic       clk_in,  // Clock
	input  wire logic       tx_in,   // Pulses from block
	input  wire logic       lvl_in,  // Level to send
	output logic            rx_out,  // Line to block
	output logic [7:0]      len_out  // Last pulse width
);
	logic [7:0] run_r = 8'h00;
	// Demodulated level straight onto the line
	assign rx_out = lvl_in;
	// Width in clocks of each pulse seen, kept until the next one
	always_ff @(posedge clk_in) begin
		run_r <= tx_in ? run_r + 8'h01 : 8'h00;
		if (!tx_in && run_r != 8'h00)
			len_out <= run_r;
	end
endmodule

// File: sim/tb.sv
/* Self-checking bench for the FIFO status and infrared block.
   Assumes the register map of sfs_regs.svh and a one-cycle ack. */
`timescale 1ns/1ps
`include "sfs_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
$display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module tb;
	logic clk, rst, msb, sby, cyc, stb, we, ack, tpu, tpo, rpu, rer, rpo;
	logic bst, bit_v, lvl, irx, itx, rxd, tclr, rclr, irm, cken, tful, remp;
	logic [7:0] adr, plen;
	logic [3:0] sel;
	logic [31:0] dat, dout, q;
	int err_count, num_checks, n;

	sfs_core u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .MOD_STANDBY_IN(msb),
		.STANDBY_IN(sby), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
		.WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dout),
		.WB_ACK_OUT(ack), .TX_PUSH_IN(tpu), .TX_POP_IN(tpo), .RX_PUSH_IN(rpu),
		.RX_ERR_IN(rer), .RX_POP_IN(rpo), .TX_BIT_START_IN(bst),
		.TX_BIT_IN(bit_v), .IR_RX_IN(irx), .IR_TX_OUT(itx),
		.RX_DATA_OUT(rxd), .TX_FIFO_CLEAR_OUT(tclr),
		.RX_FIFO_CLEAR_OUT(rclr), .IR_MODE_OUT(irm), .IR_CLK_EN_OUT(cken),
		.TX_FULL_OUT(tful), .RX_EMPTY_OUT(remp));
	sfs_ir_peer u_peer (.clk_in(clk), .tx_in(itx), .lvl_in(lvl),
		.rx_out(irx), .len_out(plen));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// One classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = dout;
		{cyc, stb, we} <= 3'b000;
		`CHK(ack, 1'b1)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, q);
	endtask
	// Strobes {tx push, tx pop, rx push, rx error, rx pop} for k clocks
	task automatic str(input int k, input logic [4:0] s);
		repeat (k) begin
			@(posedge clk);
			{tpu, tpo, rpu, rer, rpo} <= s;
		end
		@(posedge clk);
		{tpu, tpo, rpu, rer, rpo} <= 5'h00;
	endtask

	task t_fill;
		str(17, 5'h10);
		rd(`SFS_OFS_FILL, 32'h1000);
		`CHK(tful, 1'b1)
		wr(`SFS_OFS_FILL, 32'hFFFF);
		str(1, 5'h18);
		rd(`SFS_OFS_FILL, 32'h1000);
		str(2, 5'h08);
		rd(`SFS_OFS_FILL, 32'h0E00);
		str(1, 5'h06);
		str(2, 5'h04);
		str(1, 5'h06);
		str(13, 5'h04);
		rd(`SFS_OFS_FILL, 32'h0E10);
		`CHK(remp, 1'b0)
		rd(`SFS_OFS_ERRMAP, 32'h0009);
	endtask
	task t_clear;
		wr(`SFS_OFS_FIFOCTL, 32'h2);
		rd(`SFS_OFS_FILL, 32'h0E00);
		`CHK(rclr, 1'b1)
		rd(`SFS_OFS_ERRMAP, 32'h0009);
		wr(`SFS_OFS_FIFOCTL, 32'h4);
		rd(`SFS_OFS_FILL, 32'h0);
		`CHK(tclr, 1'b1)
		wr(`SFS_OFS_FIFOCTL, 32'h0);
		str(1, 5'h06);
		str(1, 5'h01);
		rd(`SFS_OFS_ERRMAP, 32'h0008);
	endtask
	task t_ir;
		wr(`SFS_OFS_IRMODE, 32'hFF);
		rd(`SFS_OFS_IRMODE, 32'hE0);
		`CHK(irm, 1'b1)
		lvl <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(rxd, 1'b0)
		wr(`SFS_OFS_IRMODE, 32'h80);
		repeat (4) @(posedge clk);
		`CHK(rxd, 1'b1)
		wr(`SFS_OFS_SERMODE, 32'h08);
		wr(`SFS_OFS_BITRATE, 32'h01);
		// Pulse clock period 2N+2 with N = 1
		n = 0;
		do @(posedge clk); while (cken !== 1'b1 && ++n < 20);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cken !== 1'b1 && n < 20);
		`CHK(n, 4)
		// Tick of 4 clocks from the divider, 2 from the bit rate
		for (int i = 0; i < 2; i++) begin
			wr(`SFS_OFS_IRMODE, i ? 32'hC0 : 32'h80);
			@(posedge clk);
			{bst, bit_v} <= 2'b10;
			@(posedge clk);
			{bst, bit_v} <= 2'b01;
			repeat (20) @(posedge clk);
			n = i ? 4 : 2;
			`CHK(plen >= 2 * n && plen <= 3 * n + 1, 1'b1)
		end
	endtask
	task t_sby;
		for (int i = 0; i < 2; i++) begin
			str(3, 5'h14);
			@(posedge clk);
			{msb, sby} <= i ? 2'b01 : 2'b10;
			repeat (6) @(posedge clk);
			{msb, sby} <= 2'b00;
			repeat (4) @(posedge clk);
			rd(`SFS_OFS_FILL, 32'h0);
			rd(`SFS_OFS_ERRMAP, 32'h0);
			rd(`SFS_OFS_IRMODE, 32'h0);
			`CHK(itx, 1'b1)
			wr(`SFS_OFS_IRMODE, 32'h80);
		end
	endtask

	task end_of_test;
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred clocks needed
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	initial begin
		{rst, msb, sby, cyc, stb, we, bst, bit_v, lvl} = 9'b100000011;
		{tpu, tpo, rpu, rer, rpo} = 5'h00;
		{adr, sel, dat} = {8'h00, 4'hF, 32'h0};
		err_count = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`SFS_OFS_FILL, 32'h0);
		rd(`SFS_OFS_IRMODE, 32'h0);
		rd(8'h1C, 32'h0);
		t_fill();
		t_clear();
		t_ir();
		t_sby();
		end_of_test();
	end
endmodule
